// ===== tsync_params.svh
`ifndef TSYNC_PARAMS_SVH
`define TSYNC_PARAMS_SVH
// Functional notes
// RULE1: network side commands, customer side responds
// RULE2: first octet is the sync type code
// RULE3: command is 26 octets, subtype 01
// RULE4: index, seconds, nanoseconds per event, twice
// RULE5: nanoseconds field always below one billion
// RULE6: first index is downstream count, multiple 16
// RULE7: second index is upstream count, fixed offset
// RULE8: first and fourth events within one superframe
// RULE9: our stamps are local clock at events
// RULE10: both clocks count from one epoch
// RULE11: exactly one reply: acknowledge or reject
// RULE12: acknowledge is 26 octets, subtype 81
// RULE13: reject is 3 octets, subtype 82, reason
// RULE14: reasons busy, invalid, gone, acquiring frequency
// RULE15: keep three latest aligned stamp pairs
// RULE16: network side should ask promptly
// RULE17: no delay asymmetry correction locally
// RULE18: unknown subtype gets invalid parameters reject
// RULE19: multi-octet fields travel most significant first
// type code is carried over from the message transport
`define TS_TYPE 8'h18
`define TS_SUB_CMD 8'h01
`define TS_SUB_ACK 8'h81
`define TS_SUB_REJ 8'h82
`define TS_RSN_NONE 8'h00
`define TS_RSN_BUSY 8'h01
`define TS_RSN_PARAM 8'h02
`define TS_RSN_GONE 8'h03
`define TS_RSN_FREQ 8'h04
`define TS_MSG_LEN 6'h1a
`define TS_REJ_LEN 6'h03
`define TS_OCT_SUB 6'h02
`define TS_OCT_IDX1_F 6'h03
`define TS_OCT_IDX1_L 6'h04
`define TS_OCT_NS1_F 6'h0b
`define TS_OCT_NS1_L 6'h0e
`define TS_OCT_NS4_F 6'h17
`define TS_OCT_NS4_L 6'h1a
`define TS_NS_LIMIT 32'h3b9aca00
`define TS_IDX_MASK 16'h000f
`define TS_DEPTH 3
`define TS_HELD_MAX 2'h3
`endif

// ===== tsync_pkg.sv
package tsync_pkg;
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_SKIP = 5'h04,
      ST_EVAL = 5'h08,
      ST_SEND = 5'h10
   } state_e;
   typedef struct packed {
      logic [15:0] idx;
      logic [47:0] sec;
      logic [31:0] ns;
   } stamp_s;
   typedef struct packed {
      stamp_s t2;
      stamp_s t3;
   } sample_s;
endpackage

// ===== octet_if.sv
`timescale 1ns/10ps
interface octet_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   logic last;
   modport src (output valid, output data, output last, input ready);
   modport snk (input valid, input data, input last, output ready);
endinterface

// ===== octet_skid.sv
`timescale 1ns/10ps
module octet_skid #(parameter int W = 8) (
   input wire logic clk,
   input wire logic rst_n,
   octet_if.snk up,
   octet_if.src dn
);
   logic [W:0] d0_r;
   logic [W:0] d1_r;
   logic v0_r;
   logic v1_r;
   logic push;
   logic pop;
   logic [W:0] in_w;

   // ready depends only on a flop, so no path from dn.ready to up.ready
   assign up.ready = !v1_r;
   assign dn.valid = v0_r;
   assign dn.data = d0_r[W-1:0];
   assign dn.last = d0_r[W];
   assign push = up.valid && !v1_r;
   assign pop = v0_r && dn.ready;
   assign in_w = {up.last, up.data};

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         v0_r <= 1'b0;
         v1_r <= 1'b0;
      end else if (pop) begin
         v0_r <= v1_r || push;
         v1_r <= 1'b0;
      end else if (push) begin
         if (v0_r) begin
            v1_r <= 1'b1;
         end else begin
            v0_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         d0_r <= '0;
         d1_r <= '0;
      end else begin
         if (pop) begin
            d0_r <= v1_r ? d1_r : in_w;
         end else if (push && !v0_r) begin
            d0_r <= in_w;
         end
         if (push && v0_r && !pop) begin
            d1_r <= in_w;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_BUF_HOLD: assert property (v0_r && !dn.ready |=>
      v0_r && $stable(d0_r))
      else $error("stalled head word changed");
   AST_BUF_FULL: assert property (v0_r && v1_r && !dn.ready |=>
      !up.ready)
      else $error("full buffer still ready");
endmodule

// ===== tsync_responder.sv
`timescale 1ns/10ps
`include "tsync_params.svh"
module tsync_responder (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   output logic RX_READY,
   output logic TX_VALID,
   output logic [7:0] TX_DATA,
   output logic TX_LAST,
   input wire logic TX_READY,
   input wire logic [47:0] RTC_SEC,
   input wire logic [31:0] RTC_NS,
   input wire logic DS_SF_EVT,
   input wire logic [15:0] DS_SF_CNT,
   input wire logic US_SF_EVT,
   input wire logic [15:0] US_SF_CNT,
   input wire logic UNIT_BUSY,
   input wire logic FREQ_ACQ,
   output logic [1:0] SAMPLES_HELD
);
   tsync_pkg::state_e st_r;
   tsync_pkg::state_e st_nxt;
   logic rx_ready_r;
   logic take;
   logic push;
   logic [5:0] cnt_r;
   logic [5:0] oct;
   logic [7:0] sub_r;
   logic [15:0] idx1_r;
   logic [31:0] ns1_r;
   logic [31:0] ns4_r;
   logic [207:0] resp_r;
   logic [5:0] left_r;
   logic param_bad;
   logic reply_c;
   logic [7:0] code_c;
   logic hit;
   tsync_pkg::sample_s hit_s;
   tsync_pkg::stamp_s pend_r;
   logic pend_v_r;
   tsync_pkg::sample_s slot_r [0:`TS_DEPTH-1];
   logic [`TS_DEPTH-1:0] slot_v_r;
   logic [1:0] wp_r;
   logic [1:0] held_r;
   logic ds_take;
   logic us_take;
   octet_if #(.W(8)) to_buf ();
   octet_if #(.W(8)) from_buf ();

   assign take = RX_VALID && rx_ready_r;
   assign oct = cnt_r + 6'h01;
   assign push = (st_r == tsync_pkg::ST_SEND) && to_buf.ready;
   assign RX_READY = rx_ready_r;
   assign SAMPLES_HELD = held_r;

   // the reply leaves through a two-word buffer so a stall loses nothing
   assign to_buf.valid = (st_r == tsync_pkg::ST_SEND);
   assign to_buf.data = resp_r[207:200];
   assign to_buf.last = (left_r == 6'h01);
   assign from_buf.ready = TX_READY;
   assign TX_VALID = from_buf.valid;
   assign TX_DATA = from_buf.data;
   assign TX_LAST = from_buf.last;

   octet_skid #(.W(8)) u_skid (
      .clk(CLK),
      .rst_n(RST_N),
      .up(to_buf),
      .dn(from_buf)
   );

   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         tsync_pkg::ST_IDLE: begin
            if (take && RX_DATA == `TS_TYPE) begin // [RULE2]
               st_nxt = RX_LAST ? tsync_pkg::ST_EVAL : tsync_pkg::ST_RECV;
            end else if (take && !RX_LAST) begin
               st_nxt = tsync_pkg::ST_SKIP;
            end
         end
         tsync_pkg::ST_RECV: begin
            if (take && RX_LAST) begin
               st_nxt = tsync_pkg::ST_EVAL;
            end
         end
         tsync_pkg::ST_SKIP: begin
            if (take && RX_LAST) begin
               st_nxt = tsync_pkg::ST_IDLE;
            end
         end
         tsync_pkg::ST_EVAL: begin
            st_nxt = reply_c ? tsync_pkg::ST_SEND : tsync_pkg::ST_IDLE;
         end
         tsync_pkg::ST_SEND: begin
            if (push && left_r == 6'h01) begin
               st_nxt = tsync_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_r <= tsync_pkg::ST_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // input is refused while a reply is pending, which back-pressures rx
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rx_ready_r <= 1'b0;
      end else begin
         rx_ready_r <= (st_nxt == tsync_pkg::ST_IDLE) ||
            (st_nxt == tsync_pkg::ST_RECV) ||
            (st_nxt == tsync_pkg::ST_SKIP);
      end
   end

   // fields shift in msb first [RULE19]
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         cnt_r <= 6'h00;
         sub_r <= 8'h00;
         idx1_r <= 16'h0000;
         ns1_r <= 32'h00000000;
         ns4_r <= 32'h00000000;
      end else if (take && st_r == tsync_pkg::ST_IDLE) begin
         cnt_r <= 6'h01;
         sub_r <= 8'h00;
      end else if (take && st_r == tsync_pkg::ST_RECV) begin
         if (cnt_r != 6'h3f) begin
            cnt_r <= oct;
         end
         if (oct == `TS_OCT_SUB) begin
            sub_r <= RX_DATA;
         end
         if (oct >= `TS_OCT_IDX1_F && oct <= `TS_OCT_IDX1_L) begin // [RULE4]
            idx1_r <= {idx1_r[7:0], RX_DATA};
         end
         if (oct >= `TS_OCT_NS1_F && oct <= `TS_OCT_NS1_L) begin // [RULE4]
            ns1_r <= {ns1_r[23:0], RX_DATA};
         end
         if (oct >= `TS_OCT_NS4_F && oct <= `TS_OCT_NS4_L) begin // [RULE4]
            ns4_r <= {ns4_r[23:0], RX_DATA};
         end
      end
   end

   // acknowledge and reject subtypes are ours to send, never to answer
   assign reply_c = (sub_r != `TS_SUB_ACK) &&
      (sub_r != `TS_SUB_REJ); // [RULE1]

   always_comb begin
      param_bad = (sub_r != `TS_SUB_CMD) || // [RULE18]
         (cnt_r != `TS_MSG_LEN) || // [RULE3]
         (ns1_r >= `TS_NS_LIMIT) || (ns4_r >= `TS_NS_LIMIT) || // [RULE5]
         ((idx1_r & `TS_IDX_MASK) != 16'h0000); // [RULE6]
   end

   // match by downstream index; the upstream half rides along [RULE7]
   always_comb begin
      hit = 1'b0;
      hit_s = '0;
      for (int i = 0; i < `TS_DEPTH; i++) begin
         if (slot_v_r[i] && slot_r[i].t2.idx == idx1_r) begin
            hit = 1'b1;
            hit_s = slot_r[i];
         end
      end
   end

   always_comb begin
      if (UNIT_BUSY) begin // [RULE14]
         code_c = `TS_RSN_BUSY;
      end else if (FREQ_ACQ) begin
         code_c = `TS_RSN_FREQ;
      end else if (param_bad) begin
         code_c = `TS_RSN_PARAM;
      end else if (!hit) begin
         code_c = `TS_RSN_GONE;
      end else begin
         code_c = `TS_RSN_NONE;
      end
   end

   // one reply per command [RULE11]
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         resp_r <= '0;
         left_r <= 6'h00;
      end else if (st_r == tsync_pkg::ST_EVAL) begin
         if (code_c == `TS_RSN_NONE) begin
            // stamps go out raw, no asymmetry correction [RULE17]
            resp_r <= {`TS_TYPE, `TS_SUB_ACK, hit_s}; // [RULE12]
            left_r <= `TS_MSG_LEN;
         end else begin
            resp_r <= {`TS_TYPE, `TS_SUB_REJ, code_c, 184'h0}; // [RULE13]
            left_r <= `TS_REJ_LEN;
         end
      end else if (push) begin
         resp_r <= {resp_r[199:0], 8'h00};
         left_r <= left_r - 6'h01;
      end
   end

   // only aligned downstream events open a sample [RULE15]
   assign ds_take = DS_SF_EVT && ((DS_SF_CNT & `TS_IDX_MASK) == 16'h0000);
   // the next upstream event closes it; pairing is fixed [RULE8]
   assign us_take = US_SF_EVT && pend_v_r;

   // stamps share the network-side epoch carried by the rtc [RULE10]
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pend_r <= '0;
         pend_v_r <= 1'b0;
      end else if (ds_take) begin
         pend_r <= {DS_SF_CNT, RTC_SEC, RTC_NS}; // [RULE9]
         pend_v_r <= 1'b1;
      end else if (us_take) begin
         pend_v_r <= 1'b0;
      end
   end

   // ring keeps the newest three; older ones are lost [RULE15]
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < `TS_DEPTH; i++) begin
            slot_r[i] <= '0;
         end
         slot_v_r <= '0;
         wp_r <= 2'h0;
         held_r <= 2'h0;
      end else if (us_take) begin
         slot_r[wp_r] <= {pend_r, US_SF_CNT, RTC_SEC, RTC_NS}; // [RULE9]
         slot_v_r[wp_r] <= 1'b1; // [RULE15]
         wp_r <= (wp_r == `TS_HELD_MAX - 2'h1) ? 2'h0 : wp_r + 2'h1;
         if (held_r != `TS_HELD_MAX) begin
            held_r <= held_r + 2'h1;
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_eval;
      st_r == tsync_pkg::ST_EVAL && reply_c;
   endsequence
   sequence s_eval_free;
      s_eval ##0 (!UNIT_BUSY && !FREQ_ACQ);
   endsequence
   sequence s_enter_send;
      st_r == tsync_pkg::ST_SEND && $past(st_r) == tsync_pkg::ST_EVAL;
   endsequence

   AST_ACK_FRAME: assert property (s_eval ##0 code_c == 8'h00 |=> // [RULE12]
      left_r == 6'h1a && resp_r[199:192] == 8'h81)
      else $error("acknowledge frame wrong");
   AST_REJ_FRAME: assert property (s_eval ##0 code_c != 8'h00 |=> // [RULE13]
      left_r == 6'h03 && resp_r[199:192] == 8'h82 &&
      resp_r[191:184] == $past(code_c))
      else $error("reject frame wrong");
   AST_FIRST_TYPE: assert property (s_enter_send |-> // [RULE2]
      to_buf.valid && to_buf.data == 8'h18)
      else $error("reply does not open with type");
   AST_BUSY_WINS: assert property (s_eval ##0 UNIT_BUSY |-> // [RULE14]
      code_c == 8'h01)
      else $error("busy not reported");
   AST_NS_BAD: assert property (s_eval_free ##0 // [RULE5]
      ns1_r >= 32'h3b9aca00 |-> code_c == 8'h02)
      else $error("bad nanoseconds accepted");
   AST_UNDEF_SUB: assert property (s_eval_free ##0 // [RULE18]
      sub_r != 8'h01 |-> code_c == 8'h02)
      else $error("undefined subtype accepted");
   AST_NOT_HELD: assert property (s_eval_free ##0 // [RULE14]
      !param_bad && !hit |=> resp_r[191:184] == 8'h03)
      else $error("missing sample not reported");
   AST_LAST_IDLE: assert property (push && to_buf.last |=> // [RULE11]
      st_r == tsync_pkg::ST_IDLE ##1 !to_buf.valid)
      else $error("more than one reply");
   AST_STORE16: assert property (us_take |=> // [RULE15]
      slot_r[$past(wp_r)].t2.idx[3:0] == 4'h0 && slot_v_r != 3'h0)
      else $error("unaligned sample stored");
   AST_T3_RTC: assert property (us_take |=> // [RULE9]
      slot_r[$past(wp_r)].t3.ns == $past(RTC_NS))
      else $error("third stamp not local clock");
   AST_HELD_CNT: assert property (us_take && held_r != 2'h3 |=> // [RULE15]
      held_r == $past(held_r) + 2'h1)
      else $error("held count not advanced");
endmodule

// ===== cmd_source.sv
`timescale 1ns/10ps
`include "tsync_params.svh"
module cmd_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_ready,
   output logic rx_valid = 1'b0,
   output logic [7:0] rx_data = 8'h00,
   output logic rx_last = 1'b0
);
   logic [8:0] q[$];
   // only this side ever originates a command, type octet first
   task automatic command(input logic [7:0] typ, input logic [7:0] sub,
         input logic [15:0] idx, input logic [31:0] ns, input int len);
      logic [207:0] v;
      logic [47:0] sec;
      sec = {16'h0000, $urandom};
      // t4 index at fixed offset, within one frame
      v = {typ, sub, idx, sec, ns, idx + 16'h0003, sec, ns};
      // same epoch seconds, sent soon after the events
      for (int i = 0; i < len; i++) begin
         q.push_back({i == len - 1, v[207 - 8 * i -: 8]});
      end
   endtask
   always @(posedge clk) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_last <= 1'b0;
      end else if (!rx_valid || rx_ready) begin
         if (q.size() > 0 && $urandom_range(2) != 0) begin
            {rx_last, rx_data} <= q.pop_front();
            rx_valid <= 1'b1;
         end else begin
            // a released line must not keep showing the old octet
            rx_valid <= 1'b0;
            rx_data <= ~rx_data;
            rx_last <= 1'b0;
         end
      end
   end
endmodule

// ===== tsync_responder_tb.sv
`timescale 1ns/10ps
`include "tsync_params.svh"
module tsync_responder_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_ready = 1'b0;
   logic hold = 1'b0;
   logic ds_evt = 1'b0;
   logic us_evt = 1'b0;
   logic busy = 1'b0;
   logic freq = 1'b0;
   logic [47:0] sec = 48'h0;
   logic [31:0] ns = 32'h0;
   logic [15:0] ds_cnt = 16'h0;
   logic [15:0] us_cnt = 16'h0;
   logic rx_valid, rx_ready, rx_last, tx_valid, tx_last;
   logic [7:0] rx_data, tx_data;
   logic [1:0] held;
   int failures = 0;
   int checks = 0;
   int sd;
   logic [8:0] expq[$];
   tsync_pkg::sample_s smp[logic [15:0]];
   logic [15:0] seq [5] = '{16'h0010, 16'h0020, 16'h0015, 16'h0030, 16'h0040};
   logic [1:0] nheld [5] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

   cmd_source PARTNER (.clk(clk), .rst_n(rst_n), .rx_ready(rx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last));
   tsync_responder DUT (.CLK(clk), .RST_N(rst_n), .RX_VALID(rx_valid),
      .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_READY(rx_ready),
      .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
      .TX_READY(tx_ready), .RTC_SEC(sec), .RTC_NS(ns), .DS_SF_EVT(ds_evt),
      .DS_SF_CNT(ds_cnt), .US_SF_EVT(us_evt), .US_SF_CNT(us_cnt),
      .UNIT_BUSY(busy), .FREQ_ACQ(freq), .SAMPLES_HELD(held));

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      if (failures == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // receiver stalls at random; hold forces a long stall to fill the buffer
   always @(posedge clk) begin
      tx_ready <= !hold && $urandom_range(3) != 0;
      sec <= {16'h0000, $urandom};
      ns <= $urandom_range(999999999);
   end

   always @(posedge clk) begin
      if (rst_n && tx_valid === 1'b1 && tx_ready) begin
         if (expq.size() == 0)
            check({7'h0, tx_last, tx_data}, 16'hffff);
         else
            check({7'h0, tx_last, tx_data},
               {7'h0, expq.pop_front()});
      end
   end

   task automatic event_pair(input logic [15:0] c, input int gap);
      tsync_pkg::stamp_s s2, s3;
      @(posedge clk);
      ds_evt <= 1'b1;
      ds_cnt <= c;
      #1 s2 = {c, sec, ns};
      @(posedge clk);
      ds_evt <= 1'b0;
      repeat (gap) @(posedge clk);
      us_evt <= 1'b1;
      us_cnt <= c + 16'h0003;
      #1 s3 = {c + 16'h0003, sec, ns};
      @(posedge clk);
      us_evt <= 1'b0;
      smp[c] = {s2, s3};
   endtask

   // rsn 00 expects an acknowledge, ff no reply, fe foreign type, no reply
   task automatic cmd(input logic [7:0] sub, input logic [15:0] idx,
         input logic [31:0] n, input int len, input logic [7:0] rsn);
      logic [207:0] v;
      int k;
      k = (rsn == 8'h00) ? 26 : 3;
      if (rsn == 8'h00)
         v = {`TS_TYPE, 8'h81, smp[idx]};
      else
         v = {`TS_TYPE, 8'h82, rsn, 184'h0};
      for (int i = 0; i < k && rsn < 8'hfe; i++) begin
         expq.push_back({i == k - 1, v[207 - 8 * i -: 8]});
      end
      PARTNER.command((rsn == 8'hfe) ? 8'h5a : `TS_TYPE, sub, idx, n, len);
      for (int i = 0; i < 800 && (PARTNER.q.size() > 0 || expq.size() > 0);
            i++) begin
         @(posedge clk);
      end
      if (PARTNER.q.size() > 0 || expq.size() > 0) begin
         check(16'h0000, 16'h0001);
         give_verdict;
      end
      // quiet spell catches a second or spurious reply
      repeat (40) @(posedge clk);
   endtask

   initial begin
      sd = $urandom(32'h8266c007);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1 check({held, rx_ready, tx_valid, tx_last, 3'h0, tx_data},
         16'h0000);
      for (int i = 0; i < 5; i++) begin
         event_pair(seq[i], i);
         #1 check({14'h0, held}, {14'h0, nheld[i]});
      end
      cmd(8'h01, 16'h0040, 32'h1234, 26, 8'h00);
      hold <= 1'b1;
      fork
         cmd(8'h01, 16'h0020, 32'h3b9ac9ff, 26, 8'h00);
         begin
            repeat (60) @(posedge clk);
            hold <= 1'b0;
         end
      join
      cmd(8'h01, 16'h0010, 32'h0, 26, 8'h03);
      cmd(8'h01, 16'h0050, 32'h0, 26, 8'h03);
      busy <= 1'b1;
      cmd(8'h01, 16'h0030, 32'h0, 26, 8'h01);
      freq <= 1'b1;
      cmd(8'h01, 16'h0030, 32'h0, 26, 8'h01);
      busy <= 1'b0;
      cmd(8'h01, 16'h0030, 32'h0, 26, 8'h04);
      freq <= 1'b0;
      cmd(8'h05, 16'h0030, 32'h0, 26, 8'h02);
      cmd(8'h01, 16'h0030, 32'h3b9aca00, 26, 8'h02);
      cmd(8'h01, 16'h0031, 32'h0, 26, 8'h02);
      cmd(8'h01, 16'h0030, 32'h0, 25, 8'h02);
      cmd(8'h81, 16'h0030, 32'h0, 26, 8'hff);
      cmd(8'h82, 16'h0030, 32'h0, 3, 8'hff);
      cmd(8'h01, 16'h0030, 32'h0, 26, 8'hfe);
      cmd(8'h01, 16'h0030, 32'h0, 1, 8'h02);
      cmd(8'h01, 16'h0030, 32'h0, 26, 8'h00);
      give_verdict;
   end
endmodule
